// *** rtl/cell_cluster.sv ***
// one cell cluster with its pin cells, routing and register controls
// assumes: APB master on pclk; ded_in and pin_in are asynchronous pins
//
// Added by the designer: register access over APB and the register offsets.
`include "cell_cluster_cfg.svh"
`default_nettype none
module cell_cluster
   import cell_cluster_pkg::*;
(
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output var  logic [31:0]          prdata,
   output var  logic                 pready,
   output var  logic                 pslverr,
   // dedicated inputs
   input  wire logic [`DEDS-1:0]     ded_in,
   // pin cells
   input  wire logic [`PINS-1:0]     pin_in,
   output var  logic [`PINS-1:0]     pin_out,
   output var  logic [`PINS-1:0]     pin_oe
);

   // ***********************
   // helpers
   // ***********************
   function automatic logic src_pick(input logic [2:0] sel,
                                     input logic [3:0] ded,
                                     input logic [3:0] intl);
      src_pick = sel[2] ? intl[sel[1:0]] : ded[sel[1:0]];
   endfunction

   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
      for (int b = 0; b < 4; b++) begin
         strb_merge[8*b +: 8] = strb[b] ? wd[8*b +: 8] : old[8*b +: 8];
      end
   endfunction

   // ***********************
   // declarations
   // ***********************
   logic [6:0]          src_q;
   logic [3:0]          int_q;
   logic [15:0]         mode_q;
   logic [23:0]         scheme_q;
   logic [31:0]         dsel_q [4];
   logic [23:0]         clksel_q;
   logic [31:0]         inv_q;
   logic [31:0]         route_q;
   logic [31:0]         pincfg_q;
   logic [31:0]         periph_q;
   logic [15:0]         lut_q [`CELLS];
   logic                pready_q;
   logic [31:0]         prdata_q;
   logic                pslverr_q;
   logic [7:0]          s1_q;
   logic [7:0]          s2_q;
   logic [7:0]          s3_q;
   logic [7:0]          filt_q;
   logic [`CELLS-1:0]   stored_q;
   logic [`CELLS-1:0]   clk_prev_q;
   logic [`PINS-1:0]    pin_reg_q;
   logic                cc0_prev_q;
   logic [`PINS-1:0]    pin_out_q;
   logic [`PINS-1:0]    pin_oe_q;

   logic [3:0]          ded;
   logic [3:0]          pin_sync;
   logic                ctrl_a;
   logic                ctrl_b;
   logic [`CELLS-1:0]   cell_out;
   logic [`CELLS-1:0]   stored_d;
   logic [`CELLS-1:0]   clk_src;
   logic [`CELLS-1:0]   f_w;
   logic [`CELLS-1:0]   carry_w;
   logic [`CELLS-1:0]   casc_w;
   logic [`CELLS-1:0]   carry_in;
   logic [`CELLS-1:0]   casc_in;
   logic [`COLS-1:0]    col_w;
   logic [`ROWS-1:0]    row_w;
   logic [`CC_LINES-1:0] cc_w;
   logic [`OE_LINES-1:0] oe_w;
   logic                pin_edge;
   logic [`PINS-1:0]    out_sig;
   logic [`PINS-1:0]    pin_col;
   logic [`PINS-1:0]    pin_reg_d;
   logic [`PINS-1:0]    pin_out_d;
   logic [`PINS-1:0]    pin_oe_d;

   // ***********************
   // apb decode
   // ***********************
   logic        addr_ok;
   logic        hit_src;
   logic        hit_int;
   logic        hit_mode;
   logic        hit_scheme;
   logic        hit_dsel;
   logic        hit_clksel;
   logic        hit_inv;
   logic        hit_route;
   logic        hit_pincfg;
   logic        hit_periph;
   logic        hit_status;
   logic        hit_cols;
   logic        hit_lut;
   logic        wr_hit;
   logic        rd_hit;
   logic        setup;
   logic        wr_go;
   logic [1:0]  dsel_idx;
   logic [2:0]  lut_idx;
   logic [31:0] status_w;
   logic [31:0] rd_data;
   logic [31:0] w_m;

   assign addr_ok    = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'b00);
   assign hit_src    = addr_ok && (paddr[7:0] == `A_SRC);
   assign hit_int    = addr_ok && (paddr[7:0] == `A_INT);
   assign hit_mode   = addr_ok && (paddr[7:0] == `A_MODE);
   assign hit_scheme = addr_ok && (paddr[7:0] == `A_SCHEME);
   assign hit_dsel   = addr_ok && (paddr[7:4] == 4'(`A_DSEL >> 4));
   assign hit_clksel = addr_ok && (paddr[7:0] == `A_CLKSEL);
   assign hit_inv    = addr_ok && (paddr[7:0] == `A_INV);
   assign hit_route  = addr_ok && (paddr[7:0] == `A_ROUTE);
   assign hit_pincfg = addr_ok && (paddr[7:0] == `A_PINCFG);
   assign hit_periph = addr_ok && (paddr[7:0] == `A_PERIPH);
   assign hit_status = addr_ok && (paddr[7:0] == `A_STATUS);
   assign hit_cols   = addr_ok && (paddr[7:0] == `A_COLS);
   assign hit_lut    = addr_ok && (paddr[7:5] == 3'(`A_LUT >> 5));
   assign wr_hit     = hit_src | hit_int | hit_mode | hit_scheme | hit_dsel
                     | hit_clksel | hit_inv | hit_route | hit_pincfg
                     | hit_periph | hit_lut;
   assign rd_hit     = wr_hit | hit_status | hit_cols;
   assign dsel_idx   = paddr[3:2];
   assign lut_idx    = paddr[4:2];
   assign setup      = psel & ~penable;
   assign wr_go      = psel & penable & pready_q & pwrite & wr_hit;

   assign status_w = {6'h00, ctrl_b, ctrl_a, ded, pin_reg_q, row_w, cell_out};
   assign rd_data =
        ({32{hit_src}}    & 32'(src_q))
      | ({32{hit_int}}    & 32'(int_q))
      | ({32{hit_mode}}   & 32'(mode_q))
      | ({32{hit_scheme}} & 32'(scheme_q))
      | ({32{hit_dsel}}   & dsel_q[dsel_idx])
      | ({32{hit_clksel}} & 32'(clksel_q))
      | ({32{hit_inv}}    & inv_q)
      | ({32{hit_route}}  & route_q)
      | ({32{hit_pincfg}} & pincfg_q)
      | ({32{hit_periph}} & periph_q)
      | ({32{hit_status}} & status_w)
      | ({32{hit_cols}}   & 32'(col_w))
      | ({32{hit_lut}}    & 32'(lut_q[lut_idx]));
   // byte lanes merged over current contents; bits above each register's width stay zero, unused bits in it (SRC bit 3, PERIPH bits 3,7,11,15,19,23) are kept
   assign w_m = strb_merge(rd_data, pwdata, pstrb);

   // ***********************
   // apb response
   // ***********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= `RST_WORD;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         // error flag stands only in the access cycle, beside pready
         pslverr_q <= setup & (pwrite ? ~wr_hit : ~rd_hit);
         if (setup) begin
            prdata_q <= pwrite ? `RST_WORD : rd_data;
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // ***********************
   // configuration registers
   // ***********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q    <= 7'h00;
         int_q    <= 4'h0;
         mode_q   <= 16'h0000;
         scheme_q <= 24'h00_0000;
         clksel_q <= 24'h00_0000;
         inv_q    <= `RST_WORD;
         route_q  <= `RST_WORD;
         pincfg_q <= `RST_WORD;
         periph_q <= `RST_WORD;
         for (int i = 0; i < 4; i++) dsel_q[i] <= `RST_WORD;
         for (int i = 0; i < `CELLS; i++) lut_q[i] <= `RST_LUT;
      end else if (wr_go) begin
         if (hit_src)    src_q    <= w_m[6:0];
         if (hit_int)    int_q    <= w_m[3:0];
         if (hit_mode)   mode_q   <= w_m[15:0];
         if (hit_scheme) scheme_q <= w_m[23:0];
         if (hit_dsel)   dsel_q[dsel_idx] <= w_m;
         if (hit_clksel) clksel_q <= w_m[23:0];
         if (hit_inv)    inv_q    <= w_m;
         if (hit_route)  route_q  <= w_m;
         if (hit_pincfg) pincfg_q <= w_m;
         if (hit_periph) periph_q <= w_m;
         if (hit_lut)    lut_q[lut_idx] <= w_m[15:0];
      end
   end

   // ***********************
   // pin input filtering
   // ***********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q   <= 8'h00;
         s2_q   <= 8'h00;
         s3_q   <= 8'h00;
         filt_q <= 8'h00;
      end else begin
         s1_q   <= {pin_in, ded_in};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
      end
   end

   assign ded      = filt_q[3:0];
   assign pin_sync = filt_q[7:4];

   assign ctrl_a = src_pick(src_q[`F_CTRL_A +: 3], ded, int_q);
   assign ctrl_b = src_pick(src_q[`F_CTRL_B +: 3], ded, int_q);

   // ***********************
   // basic cells
   // ***********************
   assign carry_in = {carry_w[`CELLS-2:0], 1'b0};
   assign casc_in  = {casc_w[`CELLS-2:0], 1'b1};

   genvar gi;
   genvar gk;
   for (gi = 0; gi < `CELLS; gi++) begin : g_cell
      logic [15:0] local_src;
      logic [3:0]  d;
      logic [3:0]  idx;
      mode_t       mode;
      scheme_t     sch;
      logic        fb;
      logic        uses_d3;
      logic        tie_one;
      logic        inv;
      logic        d3u;
      logic        lut_o;
      logic        carry_a;
      logic        ld_en;
      logic        ld_val;
      logic        clr;
      logic        reg_zero_n;
      logic        clk_edge;

      // local sources are rows, dedicated lines and internal lines, never columns
      assign local_src = {int_q, ded, row_w};
      // four data inputs from local routing
      for (gk = 0; gk < 4; gk++) begin : g_in
         assign d[gk] = local_src[dsel_q[gk][4*gi +: 4]] ^ inv_q[4*gi + gk];
      end
      assign mode = mode_t'(mode_q[2*gi +: 2]);
      assign sch  = scheme_t'(scheme_q[3*gi +: 3]);
      assign fb   = cell_out[gi];

      assign tie_one = (sch == SCH_PRESET_LOAD) | (sch == SCH_CLEAR_PRESET);
      assign uses_d3 = tie_one | (sch == SCH_LOAD_CLEAR)
                     | (sch == SCH_LOAD_PRESET) | (sch == SCH_LOAD_ONLY);
      assign inv = (sch == SCH_PRESET_INV) | (sch == SCH_LOAD_PRESET);
      // input three free for logic unless loading
      assign d3u = uses_d3 ? 1'b0 : d[3];

      // one mode steers the shared inputs
      assign idx = (mode == MODE_NORMAL) ? {d3u, d[2], d[1], d[0]} :
                   (mode == MODE_ARITH)  ? {1'b0, carry_in[gi], d[1], d[0]} :
                   (mode == MODE_UPDOWN) ? {carry_in[gi], fb, d[1], d[0]} :
                                           {d[2], carry_in[gi], fb, d[0]};
      assign lut_o   = lut_q[gi][idx];
      assign f_w[gi] = (mode == MODE_NORMAL) ? (lut_o & casc_in[gi]) : lut_o;
      assign casc_w[gi] = (mode == MODE_NORMAL) ? f_w[gi] : 1'b1;
      assign carry_a = (mode == MODE_ARITH) ? d[0] : fb;
      assign carry_w[gi] = (mode == MODE_NORMAL) ? 1'b0 :
                           (carry_a & d[1])
                           | (carry_in[gi] & (carry_a ^ d[1]));

      // load of input three (inverted in load-with-preset), or of a one in preset-load and clear-preset
      assign ld_en  = ctrl_a & uses_d3;
      assign ld_val = tie_one ? 1'b1 :
                      (sch == SCH_LOAD_PRESET) ? ~d[3] : d[3];
      assign clr = (ctrl_b & ((sch == SCH_CLEAR) | (sch == SCH_CLEAR_PRESET)
                              | (sch == SCH_LOAD_CLEAR)
                              | (sch == SCH_LOAD_PRESET)))
                 | (ctrl_a & (sch == SCH_PRESET_INV));
      // load acts through the register preset and clear
      assign reg_zero_n = ~(clr | (ld_en & ~ld_val));

      assign clk_src[gi] = src_pick(clksel_q[3*gi +: 3], ded, int_q);
      assign clk_edge    = clk_src[gi] & ~clk_prev_q[gi];
      // zero wins without a cell clock edge
      assign stored_d[gi] = ~reg_zero_n ? 1'b0 :
                            (ld_en & ld_val) ? 1'b1 :
                            clk_edge ? (f_w[gi] ^ inv) : stored_q[gi];
      assign cell_out[gi] = stored_q[gi] ^ inv;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stored_q   <= 8'h00;
         clk_prev_q <= 8'h00;
      end else begin
         stored_q   <= stored_d;
         clk_prev_q <= clk_src;
      end
   end

   // ***********************
   // row and column channels
   // ***********************
   genvar gj;
   for (gj = 0; gj < `COLS; gj++) begin : g_col
      // cell drives columns 2n and 2n+1
      assign col_w[gj] = route_q[`F_COL_EN + gj] ? cell_out[gj/2]
                                                 : pin_col[gj % `PINS];
   end
   for (gj = 0; gj < `ROWS; gj++) begin : g_row
      row_sel_t rsel;
      assign rsel = row_sel_t'(route_q[`F_ROW_SEL + 2*gj +: 2]);
      assign row_w[gj] = (rsel == ROW_COL_LO) ? col_w[gj] :
                         (rsel == ROW_COL_HI) ? col_w[gj + 8] :
                                                cell_out[gj];
   end

   // ***********************
   // peripheral control network
   // ***********************
   for (gj = 0; gj < `CC_LINES; gj++) begin : g_cc
      assign cc_w[gj] = src_pick(periph_q[`F_CC0 + 4*gj +: 3], ded, int_q);
   end
   for (gj = 0; gj < `OE_LINES; gj++) begin : g_oe
      assign oe_w[gj] = src_pick(periph_q[`F_OE0 + 4*gj +: 3], ded, int_q);
   end
   assign pin_edge = cc_w[0] & ~cc0_prev_q;

   // ***********************
   // pin cells
   // ***********************
   for (gj = 0; gj < `PINS; gj++) begin : g_pin
      pin_dir_t dir;
      pin_reg_t rm;
      logic     oe_line;
      assign dir = pin_dir_t'(pincfg_q[8*gj +: 2]);
      assign rm  = pin_reg_t'(pincfg_q[8*gj + `F_PIN_RM +: 2]);
      assign oe_line = oe_w[periph_q[`F_PIN_OE + 2*gj +: 2]];
      assign out_sig[gj] = row_w[pincfg_q[8*gj + `F_PIN_SRC +: 3]]
                         ^ pincfg_q[8*gj + `F_PIN_INV];
      assign pin_reg_d[gj] = cc_w[1] ? 1'b0 :
                             !pin_edge ? pin_reg_q[gj] :
                             (rm == PREG_IN)  ? pin_sync[gj] :
                             (rm == PREG_OUT) ? out_sig[gj] : pin_reg_q[gj];
      assign pin_col[gj]   = (rm == PREG_IN) ? pin_reg_q[gj] : pin_sync[gj];
      assign pin_out_d[gj] = (rm == PREG_OUT) ? pin_reg_d[gj] : out_sig[gj];
      assign pin_oe_d[gj]  = (dir == DIR_OUT) |
                             ((dir == DIR_BIDIR) & oe_line);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_reg_q  <= 4'h0;
         cc0_prev_q <= 1'b0;
         pin_out_q  <= 4'h0;
         pin_oe_q   <= 4'h0;
      end else begin
         pin_reg_q  <= pin_reg_d;
         cc0_prev_q <= cc_w[0];
         pin_out_q  <= pin_out_d;
         pin_oe_q   <= pin_oe_d;
      end
   end

   assign pin_out = pin_out_q;
   assign pin_oe  = pin_oe_q;

endmodule
`default_nettype wire

// *** rtl/cell_cluster_cfg.svh ***
// offsets, field positions, sizes and reset values of the cell cluster
// assumes: included by bare name before the package and the module
`ifndef CELL_CLUSTER_CFG_SVH
`define CELL_CLUSTER_CFG_SVH
// ***********************
// sizes
// ***********************
`define CELLS     8
`define COLS      16
`define ROWS      8
`define PINS      4
`define DEDS      4
`define OE_LINES  4
`define CC_LINES  2
// ***********************
// register byte offsets
// ***********************
`define A_SRC     8'h00
`define A_INT     8'h04
`define A_MODE    8'h08
`define A_SCHEME  8'h0C
`define A_DSEL    8'h10
`define A_CLKSEL  8'h20
`define A_INV     8'h24
`define A_ROUTE   8'h28
`define A_PINCFG  8'h2C
`define A_PERIPH  8'h30
`define A_STATUS  8'h34
`define A_COLS    8'h38
`define A_LUT     8'h40
// ***********************
// field positions
// ***********************
`define F_CTRL_A  0
`define F_CTRL_B  4
`define F_COL_EN  0
`define F_ROW_SEL 16
`define F_CC0     0
`define F_CC1     4
`define F_OE0     8
`define F_PIN_OE  24
`define F_PIN_RM  2
`define F_PIN_INV 4
`define F_PIN_SRC 5
// ***********************
// reset values
// ***********************
`define RST_WORD  32'h0000_0000
`define RST_LUT   16'h0000
`endif

// *** rtl/cell_cluster_pkg.sv ***
// types of the cell cluster: modes, register schemes, pin settings
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none
package cell_cluster_pkg;
   typedef enum logic [1:0] {
      MODE_NORMAL, MODE_ARITH, MODE_UPDOWN, MODE_CLRCNT
   } mode_t;
   typedef enum logic [2:0] {
      SCH_NONE, SCH_CLEAR, SCH_PRESET_LOAD, SCH_PRESET_INV,
      SCH_CLEAR_PRESET, SCH_LOAD_CLEAR, SCH_LOAD_PRESET, SCH_LOAD_ONLY
   } scheme_t;
   typedef enum logic [1:0] {DIR_IN, DIR_OUT, DIR_BIDIR, DIR_OFF} pin_dir_t;
   typedef enum logic [1:0] {PREG_NONE, PREG_IN, PREG_OUT} pin_reg_t;
   typedef enum logic [1:0] {ROW_CELL, ROW_COL_LO, ROW_COL_HI} row_sel_t;
endpackage
`default_nettype wire

// *** bench/cell_cluster_asserts.sv ***
// concurrent checks on the apb side and pin outputs of the cell cluster
// assumes: bound onto cell_cluster, single pclk domain
`default_nettype none
module cell_cluster_asserts (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pin cells
   input wire logic [3:0]  pin_out,
   input wire logic [3:0]  pin_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire setup = psel && !penable;
   // ***********************
   // register access
   // ***********************
   AST_READY_NEXT: assert property (setup |=> pready && psel)
      else $error("pready missing after setup");
   AST_READY_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_UNMAP: assert property (
      setup && paddr[31:8] != 24'h00_0000 |=> pslverr)
      else $error("unmapped address accepted");
   AST_ERR_RO: assert property (
      setup && pwrite && paddr == 32'h0000_0034 |=> pslverr)
      else $error("write to status accepted");
   AST_OK_SRC: assert property (
      setup && paddr == 32'h0000_0000 |=> !pslverr)
      else $error("mapped address refused");
   AST_ERR_DATA: assert property (
      pready && (pslverr || pwrite) |-> prdata == 32'h0000_0000)
      else $error("read data not zero");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // ***********************
   // pin outputs
   // ***********************
   AST_PIN_RESET: assert property (
      $rose(presetn) |-> pin_oe == 4'h0 && pin_out == 4'h0)
      else $error("pins not quiet after reset");
endmodule
bind cell_cluster cell_cluster_asserts chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// *** bench/cell_cluster_tb.sv ***
// directed bench of the cell cluster over apb
// assumes: checker bound separately; slave answers with pready
`include "cell_cluster_cfg.svh"
`default_nettype none
module cell_cluster_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata;
   logic [3:0]  ded_in = 0, pin_out, pin_oe;
   logic [3:0]  pin_in = 0;
   logic        pready, pslverr;
   int          failures = 0, tests_run = 0;
   cell_cluster uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ded_in(ded_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   always #50 pclk = ~pclk;
   // ***********************
   // tasks
   // ***********************
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(logic w, logic [31:0] a, logic [31:0] d,
                      output logic [31:0] r, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
      r = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wr(logic [31:0] a, logic [31:0] d, logic eer = 0);
      logic [31:0] r;
      logic        er;
      apb(1, a, d, r, er);
      chk("write err", {31'h0, eer}, {31'h0, er});
   endtask
   task automatic rd(logic [31:0] a, logic [31:0] e,
                     logic [31:0] m = 32'hFFFF_FFFF, logic eer = 0);
      logic [31:0] r;
      logic        er;
      apb(0, a, 32'h0, r, er);
      chk("read err", {31'h0, eer}, {31'h0, er});
      chk("read data", e & m, r & m);
   endtask
   task automatic pin_chk(logic [3:0] eo, logic [3:0] ee);
      repeat (3) @(negedge pclk);
      chk("pin_out", {28'h0, eo}, {28'h0, pin_out});
      chk("pin_oe", {28'h0, ee}, {28'h0, pin_oe});
   endtask
   task automatic endt(string nm);
      $display("test %s done", nm);
   endtask
   // ***********************
   // sequence
   // ***********************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      rd(`A_SRC, 0);
      rd(`A_SCHEME, 0);
      rd(`A_STATUS, 0, 32'h03FF_FFFF);
      pin_chk(4'h0, 4'h0);
      endt("reset");
      rd(32'h0000_0100, 0, 32'hFFFF_FFFF, 1);
      wr(`A_STATUS, 32'h0000_00FF, 1);
      wr(`A_COLS, 32'h0000_00FF, 1);
      endt("refusal");
      // cell n runs scheme n; line a from INT0, line b from INT1
      wr(`A_SRC, 32'h0000_0054);
      wr(`A_DSEL + 8'h0C, 32'hFFF0_0000);
      wr(`A_SCHEME, 32'h00FA_C688);
      wr(`A_INT, 32'h0000_0009);
      rd(`A_STATUS, 32'h0100_00FC, 32'h0300_00FF);
      wr(`A_INT, 32'h0000_0000);
      rd(`A_STATUS, 32'h0000_00FC, 32'h0300_00FF);
      wr(`A_INT, 32'h0000_0002);
      rd(`A_STATUS, 32'h0200_00CC, 32'h0300_00FF);
      wr(`A_INT, 32'h0000_0003);
      rd(`A_STATUS, 32'h0300_004C, 32'h0300_00FF);
      wr(`A_INT, 32'h0000_0001);
      rd(`A_STATUS, 32'h0100_001C, 32'h0300_00FF);
      endt("schemes");
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      rd(`A_SCHEME, 0);
      rd(`A_STATUS, 0, 32'h0300_00FF);
      endt("mid reset");
      // line a from dedicated input 0, line b from INT0, cell 0 clr+preset
      wr(`A_SRC, 32'h0000_0040);
      wr(`A_SCHEME, 32'h0000_0004);
      ded_in <= 4'h1;
      repeat (8) @(posedge pclk);
      rd(`A_STATUS, 32'h0110_0001, 32'h03F0_0001);
      endt("dedicated");
      // pin 0 output driven from row 0, which carries cell 0
      wr(`A_PINCFG, 32'h0000_0011);
      pin_chk(4'hE, 4'h1);
      wr(`A_PINCFG, 32'h0000_0001);
      pin_chk(4'hF, 4'h1);
      rd(`A_STATUS, 32'h0000_0100, 32'h0000_0100);
      wr(`A_PINCFG, 32'h0000_0000);
      pin_chk(4'hF, 4'h0);
      endt("pins");
      // column 1 from cell 0, row 1 from column 1
      wr(`A_ROUTE, 32'h0004_0002);
      rd(`A_COLS, 32'h0000_0002);
      rd(`A_STATUS, 32'h0000_0300, 32'h0000_FF00);
      endt("routing");
      // pin 1 capture register clocked by INT0, cleared by INT1
      pin_in <= 4'h2;
      wr(`A_PERIPH, 32'h0000_0054);
      wr(`A_PINCFG, 32'h0000_0400);
      rd(`A_STATUS, 0, 32'h000F_0000);
      wr(`A_INT, 32'h0000_0001);
      rd(`A_STATUS, 32'h0002_0000, 32'h000F_0000);
      endt("pin capture");
      tally_and_finish();
   end
endmodule
`default_nettype wire
